// File: include/pio_pattern_pkg.sv
// constants for the parallel i/o pattern selector and signal map
// assumes a single pclk domain and an apb register port
package pio_pattern_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_ZONE_LO   = 8'h04;
	localparam logic [7:0] OFF_ZONE_HI   = 8'h08;
	localparam logic [7:0] OFF_TBL_IDX   = 8'h0C;
	localparam logic [7:0] OFF_TBL_LO    = 8'h10;
	localparam logic [7:0] OFF_TBL_HI    = 8'h14;
	localparam logic [7:0] OFF_STATUS    = 8'h18;

	// ----------------------------------------------------------------
	// control and status fields
	// ----------------------------------------------------------------
	localparam int CTRL_PAT_LSB  = 0;
	localparam int CTRL_ZSRC_BIT = 2;
	localparam int STAT_POS_LSB  = 0;
	localparam int STAT_HOME_BIT = 4;
	localparam int STAT_IN_LSB   = 8;
	localparam int STAT_OUT_LSB  = 16;

	// ----------------------------------------------------------------
	// pattern codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] PAT_8POINT    = 2'h0;
	localparam logic [1:0] PAT_3DIRECT   = 2'h1;
	localparam logic [1:0] PAT_16POINT   = 2'h2;
	localparam logic [1:0] PAT_RESET     = PAT_8POINT;
	localparam logic       ZSRC_PER_POS  = 1'b0;
	localparam logic       ZSRC_GLOBAL   = 1'b1;
	localparam logic       ZSRC_RESET    = ZSRC_PER_POS;

	// ----------------------------------------------------------------
	// pin map
	// ----------------------------------------------------------------
	localparam int IN_W        = 6;
	localparam int OUT_W       = 4;
	localparam int IN_HOME_W8  = 3;
	localparam int IN_START    = 4;
	localparam int IN_PAUSE_N  = 5;
	localparam logic [IN_W-1:0] IN_IDLE = 6'h20;
	localparam int OUT_FAULT_N = 3;
	localparam int N_TARGETS   = 16;
	localparam int N_DIRECT    = 3;
endpackage : pio_pattern_pkg

// File: rtl/position_io_pattern_mux.sv
// pattern selector and signal map for the actuator parallel i/o port
// assumes pio pins are asynchronous, motion core signals are on pclk
// ----------------------------------------------------------------
// What this block does
// [RULE_01] three patterns chosen by a setting 0, 1, 2; 0 after reset
// [RULE_02] pattern 0: eight binary-coded targets and one zone output
// [RULE_03] pattern 1: three targets each on its own line, no zone output
// [RULE_04] pattern 2: sixteen binary-coded targets, one shared zone output
// [RULE_05] a setting picks per-position or global zone for pattern 2
// [RULE_06] global zone on while position in set range, only after homing
// [RULE_07] per-position range from table entry of commanded position only
// [RULE_08] patterns 0/2: in0-2 weights 1,2,4; in3 home or 8; start; pause
// [RULE_09] pattern 1: in0-2 direct moves, in3 unused, in4 clear, in5 pause
// [RULE_10] out0-2 done, homed, zone, or arrivals in pattern 1; out3 alarm
// [RULE_11] active-low lines count as asserted when off
// [RULE_12] pause off during a move stops it, resume when back on
// [RULE_13] homing done stays on until home position is lost
// ----------------------------------------------------------------
module position_io_pattern_mux
	import pio_pattern_pkg::*;
#(
	parameter int POS_W = 16
)(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [IN_W-1:0]  pio_in,
	output logic      [OUT_W-1:0] pio_out,
	input  wire logic [POS_W-1:0] core_position,
	input  wire logic             core_in_position,
	input  wire logic             core_homing_complete,
	input  wire logic             core_home_lost,
	input  wire logic             core_fault,
	input  wire logic             core_moving,
	output logic                  move_start_out,
	output logic      [3:0]       move_target_out,
	output logic                  home_start_out,
	output logic                  fault_clear_out,
	output logic                  pause_req_out
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]                      pattern;
		logic                            zone_src;
		logic [POS_W-1:0]                zone_lo;
		logic [POS_W-1:0]                zone_hi;
		logic [3:0]                      tbl_idx;
		logic [N_TARGETS-1:0][POS_W-1:0] tbl_lo;
		logic [N_TARGETS-1:0][POS_W-1:0] tbl_hi;
		logic [IN_W-1:0]                 in_s1;
		logic [IN_W-1:0]                 in_s2;
		logic [IN_W-1:0]                 in_prev;
		logic [3:0]                      cmd_pos;
		logic                            homed;
		logic [OUT_W-1:0]                outs;
		logic                            move_start;
		logic [3:0]                      move_target;
		logic                            home_start;
		logic                            fault_clear;
		logic                            pause_req;
		logic [31:0]                     rdata;
		logic                            slverr;
	} state_s;

	state_s st_reg;
	state_s st_next;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic in_range(input logic [POS_W-1:0] p,
		input logic [POS_W-1:0] lo, input logic [POS_W-1:0] hi);
		in_range = (p >= lo) && (p <= hi);
	endfunction : in_range

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == OFF_CTRL) || (a == OFF_ZONE_LO) || (a == OFF_ZONE_HI) ||
			(a == OFF_TBL_IDX) || (a == OFF_TBL_LO) || (a == OFF_TBL_HI) ||
			(a == OFF_STATUS);
	endfunction : addr_known

	logic [IN_W-1:0] rise;
	logic            global_zone;
	logic            pos_zone;
	logic            zone_out;
	logic [3:0]      bin_pos;
	logic            setup_ph;
	logic            wr_acc;

	assign rise        = st_reg.in_s2 & ~st_reg.in_prev;
	assign global_zone = st_reg.homed &&
		in_range(core_position, st_reg.zone_lo, st_reg.zone_hi); // [RULE_06]
	assign pos_zone    = in_range(core_position, st_reg.tbl_lo[st_reg.cmd_pos],
		st_reg.tbl_hi[st_reg.cmd_pos]); // [RULE_07]
	assign setup_ph    = psel && !penable;
	assign wr_acc      = psel && penable && pwrite && addr_known(paddr);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.move_start  = 1'b0;
		st_next.home_start  = 1'b0;
		st_next.fault_clear = 1'b0;

		// input synchroniser and edge history
		st_next.in_s1   = pio_in;
		st_next.in_s2   = st_reg.in_s1;
		st_next.in_prev = st_reg.in_s2;

		// binary position number, weight 8 only in pattern 2
		bin_pos = {(st_reg.pattern == PAT_16POINT) && st_reg.in_s2[IN_HOME_W8],
			st_reg.in_s2[2:0]}; // [RULE_08]

		// pause is active low on the pin
		st_next.pause_req = !st_reg.in_s2[IN_PAUSE_N]; // [RULE_11] [RULE_12]

		unique case (st_reg.pattern)
			PAT_8POINT, PAT_16POINT:
			begin
				if (rise[IN_START])
				begin
					st_next.move_start  = 1'b1; // [RULE_02] [RULE_04]
					st_next.move_target = bin_pos;
					st_next.cmd_pos     = bin_pos;
				end
				if (st_reg.pattern == PAT_8POINT && rise[IN_HOME_W8])
					st_next.home_start = 1'b1; // [RULE_08]
			end
			PAT_3DIRECT:
			begin
				for (int k = N_DIRECT - 1; k >= 0; k--)
				begin
					if (rise[k])
					begin
						st_next.move_start  = 1'b1; // [RULE_03] [RULE_09]
						st_next.move_target = 4'(k);
						st_next.cmd_pos     = 4'(k);
					end
				end
				if (rise[IN_START])
					st_next.fault_clear = 1'b1; // [RULE_09]
			end
			default:
			begin
			end
		endcase

		// homed latch, a new completion wins over a loss
		if (core_homing_complete)
			st_next.homed = 1'b1; // [RULE_13]
		else if (core_home_lost)
			st_next.homed = 1'b0; // [RULE_13]

		// output pin map
		if (st_reg.pattern == PAT_3DIRECT)
		begin
			for (int k = 0; k < N_DIRECT; k++)
				st_next.outs[k] = core_in_position && !core_moving &&
					(st_reg.cmd_pos == 4'(k)); // [RULE_10]
		end
		else
		begin
			st_next.outs[0] = core_in_position && !core_moving; // [RULE_10]
			st_next.outs[1] = st_reg.homed; // [RULE_10]
			st_next.outs[2] = zone_out; // [RULE_10]
		end
		st_next.outs[OUT_FAULT_N] = !core_fault; // [RULE_10] [RULE_11]

		// apb read data captured in the setup phase
		if (setup_ph)
		begin
			st_next.slverr = !addr_known(paddr);
			st_next.rdata  = 32'h0000_0000;
			unique case (paddr)
				OFF_CTRL:
				begin
					st_next.rdata[CTRL_PAT_LSB +: 2] = st_reg.pattern;
					st_next.rdata[CTRL_ZSRC_BIT]     = st_reg.zone_src;
				end
				OFF_ZONE_LO: st_next.rdata[POS_W-1:0] = st_reg.zone_lo;
				OFF_ZONE_HI: st_next.rdata[POS_W-1:0] = st_reg.zone_hi;
				OFF_TBL_IDX: st_next.rdata[3:0]       = st_reg.tbl_idx;
				OFF_TBL_LO:  st_next.rdata[POS_W-1:0] = st_reg.tbl_lo[st_reg.tbl_idx];
				OFF_TBL_HI:  st_next.rdata[POS_W-1:0] = st_reg.tbl_hi[st_reg.tbl_idx];
				OFF_STATUS:
				begin
					st_next.rdata[STAT_POS_LSB +: 4]     = st_reg.cmd_pos;
					st_next.rdata[STAT_HOME_BIT]         = st_reg.homed;
					st_next.rdata[STAT_IN_LSB +: IN_W]   = st_reg.in_s2;
					st_next.rdata[STAT_OUT_LSB +: OUT_W] = st_reg.outs;
				end
				default:
				begin
				end
			endcase
		end

		// apb writes
		if (wr_acc)
		begin
			unique case (paddr)
				OFF_CTRL:
				begin
					if (pwdata[CTRL_PAT_LSB +: 2] != 2'h3)
						st_next.pattern = pwdata[CTRL_PAT_LSB +: 2]; // [RULE_01]
					st_next.zone_src = pwdata[CTRL_ZSRC_BIT]; // [RULE_05]
				end
				OFF_ZONE_LO: st_next.zone_lo = pwdata[POS_W-1:0]; // [RULE_06]
				OFF_ZONE_HI: st_next.zone_hi = pwdata[POS_W-1:0]; // [RULE_06]
				OFF_TBL_IDX: st_next.tbl_idx = pwdata[3:0];
				OFF_TBL_LO:  st_next.tbl_lo[st_reg.tbl_idx] = pwdata[POS_W-1:0]; // [RULE_07]
				OFF_TBL_HI:  st_next.tbl_hi[st_reg.tbl_idx] = pwdata[POS_W-1:0]; // [RULE_07]
				default:
				begin
				end
			endcase
		end
	end

	// zone source, pattern 0 global only, pattern 1 none
	always_comb
	begin
		zone_out = 1'b0;
		unique case (st_reg.pattern)
			PAT_8POINT:  zone_out = global_zone; // [RULE_02]
			PAT_16POINT: zone_out = (st_reg.zone_src == ZSRC_GLOBAL) ?
				global_zone : pos_zone; // [RULE_04] [RULE_05]
			default:     zone_out = 1'b0; // [RULE_03]
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg          <= '0;
			st_reg.pattern  <= PAT_RESET; // [RULE_01]
			st_reg.zone_src <= ZSRC_RESET;
			st_reg.in_s1    <= IN_IDLE; // [RULE_11]
			st_reg.in_s2    <= IN_IDLE;
			st_reg.in_prev  <= IN_IDLE;
		end
		else
			st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata          = st_reg.rdata;
	assign pready          = 1'b1;
	assign pslverr         = psel && penable && st_reg.slverr;
	assign pio_out         = st_reg.outs;
	assign move_start_out  = st_reg.move_start;
	assign move_target_out = st_reg.move_target;
	assign home_start_out  = st_reg.home_start;
	assign fault_clear_out = st_reg.fault_clear;
	assign pause_req_out   = st_reg.pause_req;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_pattern_legal;
		st_reg.pattern != 2'h3;
	endproperty
	a_pattern_legal: // [RULE_01]
	assert property (p_pattern_legal) else $error("illegal pattern held");

	property p_no_zone_p1;
		st_reg.pattern == PAT_3DIRECT |-> !zone_out;
	endproperty
	a_no_zone_p1: // [RULE_03]
	assert property (p_no_zone_p1) else $error("zone driven in pattern 1");

	property p_start_bin;
		(st_reg.pattern == PAT_8POINT) && rise[IN_START] |=>
			move_start_out && move_target_out == {1'b0, $past(st_reg.in_s2[2:0])};
	endproperty
	a_start_bin: // [RULE_08]
	assert property (p_start_bin) else $error("binary start not issued");

	property p_direct;
		(st_reg.pattern == PAT_3DIRECT) && rise[1] && !rise[0] |=>
			move_start_out && move_target_out == 4'h1;
	endproperty
	a_direct: // [RULE_09]
	assert property (p_direct) else $error("direct move to 1 missing");

	property p_global_homed;
		(st_reg.pattern == PAT_8POINT) && !st_reg.homed |=> !pio_out[2];
	endproperty
	a_global_homed: // [RULE_06]
	assert property (p_global_homed) else $error("zone before homing");

	property p_homed_hold;
		st_reg.homed && !core_home_lost |=> st_reg.homed;
	endproperty
	a_homed_hold: // [RULE_13]
	assert property (p_homed_hold) else $error("homed dropped");

	property p_alarm;
		core_fault |=> !pio_out[OUT_FAULT_N];
	endproperty
	a_alarm: // [RULE_10]
	assert property (p_alarm) else $error("alarm line not off");

	property p_pause;
		!st_reg.in_s2[IN_PAUSE_N] |=> pause_req_out;
	endproperty
	a_pause: // [RULE_12]
	assert property (p_pause) else $error("pause not requested");

	property p_zsrc;
		(st_reg.pattern == PAT_16POINT) && (st_reg.zone_src == ZSRC_GLOBAL) |->
			zone_out == global_zone;
	endproperty
	a_zsrc: // [RULE_05]
	assert property (p_zsrc) else $error("zone source ignored");

	property p_home_p2;
		(st_reg.pattern == PAT_16POINT) |=> !home_start_out;
	endproperty
	a_home_p2: // [RULE_04]
	assert property (p_home_p2) else $error("home issued in pattern 2");

	c_start16: cover property (st_reg.pattern == PAT_16POINT && move_start_out);
	c_direct2: cover property (st_reg.pattern == PAT_3DIRECT && move_target_out == 4'h2
		&& move_start_out);
	c_home:    cover property (home_start_out ##[1:50] st_reg.homed);
	c_per_target_range_out:   cover property (st_reg.pattern == PAT_16POINT && pos_zone && pio_out[2]);
endmodule : position_io_pattern_mux

// File: verif/host_plc_model.sv
// host controller stand-in driving the six parallel input pins
// assumes the bench hands it wanted pin levels, synchronous to pclk
module host_plc_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [5:0] want,
	output logic      [5:0] pio_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pio_in <= 6'h20;
		else
		begin
			pio_in[3:0] <= want[3:0];
			pio_in[4]   <= want[4] && (pio_in[3:0] == want[3:0]);
			pio_in[5]   <= want[5];
		end
	end
endmodule : host_plc_model

// File: verif/position_io_pattern_mux_test.sv
// self-checking bench for the pattern selector and signal map
// assumes host_plc_model drives the pins; apb master and core stand-in live here
module position_io_pattern_mux_test
	import pio_pattern_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic        pready, pslverr, mv, hm, fc, pz;
	logic [5:0]  want = 6'h20, pio_in;
	logic [3:0]  pio_out, tgt, t;
	logic [15:0] pos = 16'h0000;
	logic        inp = 0, hc = 0, hl = 0, flt = 0, mov = 0;
	logic [35:0] got, expq[$];
	int          failures = 0, compares = 0;
	always #2.5 pclk = ~pclk;
	host_plc_model u_plc (.pclk(pclk), .presetn(presetn), .want(want), .pio_in(pio_in));
	position_io_pattern_mux u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pio_in(pio_in),
		.pio_out(pio_out), .core_position(pos), .core_in_position(inp),
		.core_homing_complete(hc), .core_home_lost(hl), .core_fault(flt),
		.core_moving(mov), .move_start_out(mv), .move_target_out(tgt),
		.home_start_out(hm), .fault_clear_out(fc), .pause_req_out(pz));
	// ----------------------------------------------------------------
	// verdict and compares
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	task automatic cmp_event(input logic [35:0] g, input logic [35:0] e);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp_event
	task automatic cmp_level(input logic [4:0] e);
		compares++;
		if ({pz, pio_out} !== e)
		begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, {pz, pio_out}, e);
		end
	endtask : cmp_level
	// ----------------------------------------------------------------
	// result watcher
	// ----------------------------------------------------------------
	always @(posedge pclk)
		if (presetn && (mv || hm || fc || (psel && penable && !pwrite && pready)))
		begin
			got = mv ? {4'h1, 32'(tgt)} : hm ? {4'h2, 32'h0000_0000} :
				fc ? {4'h3, 32'h0000_0000} : {3'h2, pslverr, prdata};
			cmp_event(got, expq.size() > 0 ? expq.pop_front() : 36'h0_0000_0000);
		end
	// ----------------------------------------------------------------
	// drivers
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			failures++;
			report_and_stop();
		end
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
		expq.push_back({3'h2, err, e});
		apb(1'b0, a, 32'h0000_0000);
		repeat (2) @(posedge pclk);
	endtask : rd
	task automatic pins(input logic [5:0] v);
		@(posedge pclk);
		want <= v;
		repeat (6) @(posedge pclk);
	endtask : pins
	task automatic fire(input logic [5:0] v, input logic [5:0] m, input logic [35:0] e);
		pins(v);
		if (e[35:32] != 4'h0)
			expq.push_back(e);
		pins(v | m);
		for (int n = 0; n < 20 && expq.size() > 0; n++)
			@(posedge pclk);
		if (expq.size() > 0)
		begin
			failures++;
			report_and_stop();
		end
		pins(v);
	endtask : fire
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(86514));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_CTRL, 32'h0000_0000, 1'b0);
		rd(8'h1C, 32'h0000_0000, 1'b1);
		pins(6'h20);
		cmp_level(5'h08);
		for (int i = 0; i < 6; i++)
		begin
			t = (i == 0) ? 4'h7 : 4'($urandom_range(7));
			fire({2'b10, 1'b0, t[2:0]}, 6'h10, {4'h1, 32'(t)});
		end
		fire(6'h20, 6'h08, {4'h2, 32'h0000_0000});
		pins(6'h00);
		cmp_level(5'h18);
		pins(6'h20);
		apb(1'b1, OFF_ZONE_LO, 32'h0000_0064);
		apb(1'b1, OFF_ZONE_HI, 32'h0000_00C8);
		@(posedge pclk) pos <= 16'h0096;
		@(posedge pclk) inp <= 1'b1;
		repeat (3) @(posedge pclk);
		cmp_level(5'h09);
		@(posedge pclk) hc <= 1'b1;
		@(posedge pclk) hc <= 1'b0;
		repeat (3) @(posedge pclk);
		cmp_level(5'h0F);
		@(posedge pclk) pos <= 16'h00C9;
		repeat (3) @(posedge pclk);
		cmp_level(5'h0B);
		@(posedge pclk) pos <= 16'h00C8;
		@(posedge pclk) mov <= 1'b1;
		@(posedge pclk) flt <= 1'b1;
		repeat (3) @(posedge pclk);
		cmp_level(5'h06);
		@(posedge pclk) hl <= 1'b1;
		@(posedge pclk) hl <= 1'b0;
		repeat (3) @(posedge pclk);
		cmp_level(5'h00);
		@(posedge pclk) flt <= 1'b0;
		@(posedge pclk) mov <= 1'b0;
		apb(1'b1, OFF_CTRL, 32'h0000_0002);
		rd(OFF_CTRL, 32'h0000_0002, 1'b0);
		apb(1'b1, OFF_TBL_IDX, 32'h0000_0005);
		apb(1'b1, OFF_TBL_LO, 32'h0000_000A);
		apb(1'b1, OFF_TBL_HI, 32'h0000_0014);
		rd(OFF_TBL_LO, 32'h0000_000A, 1'b0);
		for (int i = 0; i < 6; i++)
		begin
			t = (i == 0) ? 4'hF : 4'($urandom_range(15));
			fire({2'b10, t}, 6'h10, {4'h1, 32'(t)});
		end
		@(posedge pclk) pos <= 16'h000F;
		fire(6'h25, 6'h10, {4'h1, 32'h0000_0005});
		cmp_level(5'h0D);
		fire(6'h26, 6'h10, {4'h1, 32'h0000_0006});
		cmp_level(5'h09);
		@(posedge pclk) hc <= 1'b1;
		@(posedge pclk) hc <= 1'b0;
		@(posedge pclk) pos <= 16'h0096;
		repeat (3) @(posedge pclk);
		cmp_level(5'h0B);
		apb(1'b1, OFF_CTRL, 32'h0000_0006);
		repeat (3) @(posedge pclk);
		cmp_level(5'h0F);
		apb(1'b1, OFF_CTRL, 32'h0000_0001);
		apb(1'b1, OFF_CTRL, 32'h0000_0003);
		rd(OFF_CTRL, 32'h0000_0001, 1'b0);
		for (int k = 0; k < 3; k++)
		begin
			fire(6'h20, 6'(1 << k), {4'h1, 32'(k)});
			cmp_level({2'b01, 3'(1 << k)});
		end
		fire(6'h20, 6'h10, {4'h3, 32'h0000_0000});
		fire(6'h20, 6'h08, 36'h0_0000_0000);
		report_and_stop();
	end
endmodule : position_io_pattern_mux_test
